// [rtl/rate_select_pkg.sv]
/*
  Constants shared by the rate select and line monitor block: register
  addresses, field positions, values after reset, divider ratios and
  filter length.
  Assumes a 16-bit register address space and 8-bit registers.
*/
package rate_select_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] PORT3_DIRECTION_ADDR = 16'hff23;
  localparam logic [15:0] BUS_RATE_SELECT_ADDR = 16'hffaa;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] PORT3_DIRECTION_RESET = 8'hff;
  localparam logic [7:0] BUS_RATE_SELECT_RESET = 8'h00;
  localparam logic LINE_IDLE_LEVEL = 1'b1;

  // ----------------------------------------------------------------
  // Field positions of the rate select register
  // ----------------------------------------------------------------
  localparam int CLOCK_FLAG_BIT = 5;
  localparam int DATA_FLAG_BIT = 4;
  localparam int SPEED_MODE_BIT = 3;
  localparam int NOISE_FILTER_BIT = 2;
  localparam int RATE_DIVIDER_BIT = 0;

  // ----------------------------------------------------------------
  // Port 3 layout
  // ----------------------------------------------------------------
  localparam int PORT3_PINS = 7;
  localparam int DATA_PIN = 2;
  localparam int CLOCK_PIN = 3;
  localparam int DIRECTION_FIXED_BIT = 7;

  // ----------------------------------------------------------------
  // Bus clock divider ratios in system clock cycles
  // ----------------------------------------------------------------
  localparam int DIV_WIDTH = 7;
  localparam logic [DIV_WIDTH-1:0] DIV_STANDARD_FAST = 7'd44;
  localparam logic [DIV_WIDTH-1:0] DIV_STANDARD_SLOW = 7'd86;
  localparam logic [DIV_WIDTH-1:0] DIV_HIGH_SPEED = 7'd24;

  // ----------------------------------------------------------------
  // Noise filter: samples a new level must hold before it is taken
  // ----------------------------------------------------------------
  localparam int FILTER_CNT_WIDTH = 2;
  localparam logic [FILTER_CNT_WIDTH-1:0] FILTER_LAST = 2'd2;

endpackage

// [rtl/line_filter.sv]
/*
  One bus line input: a two-stage synchroniser followed by an optional
  digital noise filter.
  Assumes the line level is asynchronous to mclk; the filter switch is
  a level from the register file.
*/
`timescale 1ns/1ps
`default_nettype none
module line_filter
  import rate_select_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic line_in,
  input wire logic filter_on,
  output logic sync_level,
  output logic level_out
);

  logic sync_first;
  logic [FILTER_CNT_WIDTH-1:0] hold_cnt;

  // ----------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------
  // Two flops; only the second stage is read by other logic
  always_ff @(posedge mclk) begin
    if (rst) begin
      sync_first <= LINE_IDLE_LEVEL;
      sync_level <= LINE_IDLE_LEVEL;
    end else begin
      sync_first <= line_in; // RQ15
      sync_level <= sync_first; // RQ15
    end
  end

  // ----------------------------------------------------------------
  // Noise filter
  // ----------------------------------------------------------------
  // A change is taken at once when off, after several equal samples when on
  always_ff @(posedge mclk) begin
    if (rst) begin
      level_out <= LINE_IDLE_LEVEL;
      hold_cnt <= '0;
    end else if (sync_level == level_out) begin
      hold_cnt <= '0;
    end else if (!filter_on || hold_cnt == FILTER_LAST) begin
      level_out <= sync_level; // RQ6
      hold_cnt <= '0;
    end else begin
      hold_cnt <= hold_cnt + 1'b1; // RQ7
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_sync_two_stage;
    @(posedge mclk) disable iff (rst)
      ##1 sync_level == $past(line_in, 2);
  endproperty
  a_sync_two_stage: assert property (p_sync_two_stage) // RQ15
    else $error("synchroniser is not two stages deep");

  property p_filter_delays;
    @(posedge mclk) disable iff (rst)
      filter_on && $changed(sync_level) ##1 filter_on |-> level_out == $past(level_out);
  endproperty
  a_filter_delays: assert property (p_filter_delays) // RQ7
    else $error("filtered level changed without a hold period");

endmodule
`default_nettype wire

// [rtl/i2c_rate_select_line_monitor.sv]
/*
  Rate select and line monitor of the two-wire serial bus unit: the
  rate select register, the port 3 direction register, the bus clock
  divider, line level flags and open-drain pin control.
  Assumes the protocol engine and the control register lie outside:
  they supply the unit enable and pull-low requests and take the
  filtered line levels and the bus clock enable. The pins are resolved
  outside from the output enables; pull-ups give the high level.
*/
// Notes on behaviour
// [RQ1] Clock flag shows sampled clock line level
// [RQ2] Data flag shows sampled data line level
// [RQ3] Flags zero while unit disabled or reset
// [RQ4] Flag bits read-only; bits 7,6,1 read zero
// [RQ5] Speed mode bit: standard or high speed
// [RQ6] Filter bit switches digital noise filter
// [RQ7] Filter delays response, meant for high speed
// [RQ8] Filter toggle leaves high-speed rate unchanged
// [RQ9] Divide by 44/86 standard, 24 high speed
// [RQ10] Software halts transfer before changing rate bit
// [RQ11] Software clears pin direction and latches first
// [RQ12] Direction bit 0 enables pin output buffer
// [RQ13] Direction register resets to ones; bit 7 one
// [RQ14] Bus pins open-drain pull-low only, sampled inputs
// [RQ15] Flags taken after two-stage synchroniser
`timescale 1ns/1ps
`default_nettype none
module i2c_rate_select_line_monitor
  import rate_select_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic bus_unit_enable,
  input wire logic clock_pull_low,
  input wire logic data_pull_low,
  input wire logic [PORT3_PINS-1:0] port3_out_latch,
  input wire logic [PORT3_PINS-1:0] port3_pin_in,
  output logic [PORT3_PINS-1:0] port3_pin_out,
  output logic [PORT3_PINS-1:0] port3_pin_oe,
  output logic clock_line_filtered,
  output logic data_line_filtered,
  output logic bus_clock_enable,
  output logic speed_mode_select,
  output logic noise_filter_enable
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic rate_divider_select;
  logic clock_line_level_flag;
  logic data_line_level_flag;
  logic [PORT3_PINS-1:0] port3_direction_reg;
  logic [1:0] line_raw;
  logic [1:0] line_sync;
  logic [1:0] line_filt;
  logic [DIV_WIDTH-1:0] div_cnt;
  logic [DIV_WIDTH-1:0] cur_div;
  logic wr_rate;
  logic wr_dir;

  // Divider ratio for a mode and rate select
  function automatic logic [DIV_WIDTH-1:0] div_ratio(input logic high_speed,
                                                     input logic slow);
    if (high_speed) begin
      div_ratio = DIV_HIGH_SPEED;
    end else if (slow) begin
      div_ratio = DIV_STANDARD_SLOW;
    end else begin
      div_ratio = DIV_STANDARD_FAST;
    end
  endfunction

  assign cur_div = div_ratio(speed_mode_select, rate_divider_select); // RQ8
  assign wr_rate = reg_wr && reg_addr == BUS_RATE_SELECT_ADDR;
  assign wr_dir = reg_wr && reg_addr == PORT3_DIRECTION_ADDR;

  // ----------------------------------------------------------------
  // Line input stages
  // ----------------------------------------------------------------
  assign line_raw = {port3_pin_in[CLOCK_PIN], port3_pin_in[DATA_PIN]};

  // One synchroniser and filter per bus line; index 1 clock, 0 data
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_line
      line_filter u_filter (
        .mclk(mclk),
        .rst(rst),
        .line_in(line_raw[g]),
        .filter_on(noise_filter_enable),
        .sync_level(line_sync[g]),
        .level_out(line_filt[g])
      );
    end
  endgenerate

  assign clock_line_filtered = line_filt[1];
  assign data_line_filtered = line_filt[0];

  // ----------------------------------------------------------------
  // Rate select register
  // ----------------------------------------------------------------
  // Software-written mode, filter and rate fields; flag bits ignore writes
  always_ff @(posedge mclk) begin
    if (rst) begin
      speed_mode_select <= BUS_RATE_SELECT_RESET[SPEED_MODE_BIT]; // RQ5
      noise_filter_enable <= BUS_RATE_SELECT_RESET[NOISE_FILTER_BIT];
      rate_divider_select <= BUS_RATE_SELECT_RESET[RATE_DIVIDER_BIT];
    end else if (wr_rate) begin
      speed_mode_select <= reg_wdata[SPEED_MODE_BIT]; // RQ5
      noise_filter_enable <= reg_wdata[NOISE_FILTER_BIT]; // RQ6
      rate_divider_select <= reg_wdata[RATE_DIVIDER_BIT]; // RQ10
    end
  end

  // Line level flags follow the synchronised lines while enabled
  always_ff @(posedge mclk) begin
    if (rst || !bus_unit_enable) begin
      clock_line_level_flag <= 1'b0; // RQ3
      data_line_level_flag <= 1'b0; // RQ3
    end else begin
      clock_line_level_flag <= line_sync[1]; // RQ1
      data_line_level_flag <= line_sync[0]; // RQ2
    end
  end

  // ----------------------------------------------------------------
  // Port 3 direction register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      port3_direction_reg <= PORT3_DIRECTION_RESET[PORT3_PINS-1:0]; // RQ13
    end else if (wr_dir) begin
      port3_direction_reg <= reg_wdata[PORT3_PINS-1:0]; // RQ11
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  // Read data stand only in the cycle after the strobe; unmapped reads 0
  always_ff @(posedge mclk) begin
    if (rst || !reg_rd) begin
      reg_rdata <= 8'h00;
    end else if (reg_addr == BUS_RATE_SELECT_ADDR) begin
      reg_rdata <= 8'h00; // RQ4
      reg_rdata[CLOCK_FLAG_BIT] <= clock_line_level_flag;
      reg_rdata[DATA_FLAG_BIT] <= data_line_level_flag;
      reg_rdata[SPEED_MODE_BIT] <= speed_mode_select;
      reg_rdata[NOISE_FILTER_BIT] <= noise_filter_enable;
      reg_rdata[RATE_DIVIDER_BIT] <= rate_divider_select;
    end else if (reg_addr == PORT3_DIRECTION_ADDR) begin
      reg_rdata <= {1'b1, port3_direction_reg}; // RQ13
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Bus clock divider
  // ----------------------------------------------------------------
  // One-cycle enable every cur_div system clocks while the unit runs
  always_ff @(posedge mclk) begin
    if (rst || !bus_unit_enable) begin
      div_cnt <= '0;
      bus_clock_enable <= 1'b0;
    end else if (div_cnt >= cur_div - 1'b1) begin
      div_cnt <= '0; // RQ9
      bus_clock_enable <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 1'b1;
      bus_clock_enable <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // Plain port pins drive their latch when the direction bit is 0;
  // bus pins only pull low while the unit is enabled
  always_ff @(posedge mclk) begin
    if (rst) begin
      port3_pin_out <= '0;
      port3_pin_oe <= '0;
    end else begin
      for (int i = 0; i < PORT3_PINS; i++) begin
        port3_pin_out[i] <= port3_out_latch[i];
        port3_pin_oe[i] <= !port3_direction_reg[i]; // RQ12
      end
      if (bus_unit_enable) begin
        port3_pin_out[CLOCK_PIN] <= 1'b0; // RQ14
        port3_pin_out[DATA_PIN] <= 1'b0; // RQ14
        port3_pin_oe[CLOCK_PIN] <= !port3_direction_reg[CLOCK_PIN] && clock_pull_low;
        port3_pin_oe[DATA_PIN] <= !port3_direction_reg[DATA_PIN] && data_pull_low;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Helper: cycles since the last divider pulse and whether ratio held
  logic [DIV_WIDTH:0] gap_cnt;
  logic gap_valid;
  always_ff @(posedge mclk) begin
    if (rst || !bus_unit_enable) begin
      gap_cnt <= '0;
      gap_valid <= 1'b0;
    end else if (bus_clock_enable) begin
      gap_cnt <= (DIV_WIDTH + 1)'(1);
      gap_valid <= 1'b1;
    end else begin
      gap_cnt <= gap_cnt + 1'b1;
      if ($past(cur_div) != cur_div) begin
        gap_valid <= 1'b0;
      end
    end
  end

  property p_clock_flag;
    @(posedge mclk) disable iff (rst)
      bus_unit_enable ##1 bus_unit_enable |-> clock_line_level_flag == $past(line_sync[1]);
  endproperty
  a_clock_flag: assert property (p_clock_flag) // RQ1
    else $error("clock flag does not follow the clock line");

  property p_data_flag;
    @(posedge mclk) disable iff (rst)
      bus_unit_enable |=> data_line_level_flag == $past(line_raw[0], 3);
  endproperty
  a_data_flag: assert property (p_data_flag) // RQ2
    else $error("data flag does not follow the data line");

  property p_flags_off;
    @(posedge mclk) disable iff (rst)
      !bus_unit_enable |=> !clock_line_level_flag && !data_line_level_flag;
  endproperty
  a_flags_off: assert property (p_flags_off) // RQ3
    else $error("line flags set while the unit is disabled");

  property p_read_zero_bits;
    @(posedge mclk) disable iff (rst)
      reg_rd && reg_addr == BUS_RATE_SELECT_ADDR
        |=> reg_rdata[7:6] == 2'b00 && !reg_rdata[1]
            && reg_rdata[CLOCK_FLAG_BIT] == $past(clock_line_level_flag);
  endproperty
  a_read_zero_bits: assert property (p_read_zero_bits) // RQ4
    else $error("rate register read shows wrong fixed or flag bits");

  property p_mode_write;
    @(posedge mclk) disable iff (rst)
      wr_rate |=> speed_mode_select == $past(reg_wdata[SPEED_MODE_BIT])
                  && noise_filter_enable == $past(reg_wdata[NOISE_FILTER_BIT]);
  endproperty
  a_mode_write: assert property (p_mode_write) // RQ5
    else $error("mode or filter bit not taken from a write");

  property p_divider_gap;
    @(posedge mclk) disable iff (rst)
      bus_clock_enable && gap_valid |-> gap_cnt == {1'b0, $past(cur_div)};
  endproperty
  a_divider_gap: assert property (p_divider_gap) // RQ9
    else $error("bus clock pulses not spaced by the divider ratio");

  property p_filter_rate;
    @(posedge mclk) disable iff (rst)
      speed_mode_select && $changed(noise_filter_enable) && $stable(speed_mode_select)
        |-> cur_div == DIV_HIGH_SPEED;
  endproperty
  a_filter_rate: assert property (p_filter_rate) // RQ8
    else $error("filter toggle changed the high-speed rate");

  property p_port_oe;
    @(posedge mclk) disable iff (rst)
      1'b1 |=> port3_pin_oe[0] == !$past(port3_direction_reg[0])
               && port3_pin_oe[6] == !$past(port3_direction_reg[6]);
  endproperty
  a_port_oe: assert property (p_port_oe) // RQ12
    else $error("port output buffer disagrees with direction bit");

  property p_dir_read;
    @(posedge mclk) disable iff (rst)
      reg_rd && reg_addr == PORT3_DIRECTION_ADDR |=> reg_rdata[DIRECTION_FIXED_BIT];
  endproperty
  a_dir_read: assert property (p_dir_read) // RQ13
    else $error("direction register bit 7 did not read as one");

  property p_open_drain;
    @(posedge mclk) disable iff (rst)
      bus_unit_enable |=> !port3_pin_out[CLOCK_PIN] && !port3_pin_out[DATA_PIN];
  endproperty
  a_open_drain: assert property (p_open_drain) // RQ14
    else $error("bus pin driven high");

endmodule
`default_nettype wire

// [dv/bus_far_device.sv]
/*
  Far side of the two-wire bus: other masters and slaves that share
  the clock and data lines, plus the pull-up resistors.
  Assumes the bench commands when the far device pulls a line low and
  that the block's pins are open-drain outputs qualified by enables.
*/
`timescale 1ns/1ps
`default_nettype none
module bus_far_device (
  input wire logic clock_oe,
  input wire logic clock_out,
  input wire logic data_oe,
  input wire logic data_out,
  input wire logic hold_clock_low,
  input wire logic hold_data_low,
  output logic clock_line,
  output logic data_line
);
  // --------------------------------------------------------------
  // Wired-AND lines
  // --------------------------------------------------------------
  // Any party driving low wins, otherwise the pull-up gives high
  assign clock_line = !((clock_oe && !clock_out) || hold_clock_low);
  assign data_line = !((data_oe && !data_out) || hold_data_low);
endmodule
`default_nettype wire

// [dv/testbench.sv]
/*
  Self-checking bench for the rate select and line monitor block.
  Assumes the far device model, the package and the design files are
  compiled first; one 25 MHz clock, synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench
  import rate_select_pkg::*;
;
  logic mclk, rst, reg_wr, reg_rd, bus_unit_enable, clock_pull_low, data_pull_low;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd;
  logic [PORT3_PINS-1:0] port3_out_latch, port3_pin_in, port3_pin_out, port3_pin_oe, other_in;
  logic clock_line_filtered, data_line_filtered, bus_clock_enable;
  logic speed_mode_select, noise_filter_enable, clock_line, data_line;
  logic hold_clock_low, hold_data_low;
  int miscompares, checks, mdl_rate, mdl_dir, first, lows;
  int tab_rate [5] = '{8'h00, 8'h01, 8'h08, 8'h0c, 8'h09};
  int tab_div [5] = '{44, 86, 24, 24, 24};

  // --------------------------------------------------------------
  // Clock, pins and instances
  // --------------------------------------------------------------
  // Free-running system clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  assign port3_pin_in = {other_in[6:4], clock_line, data_line, other_in[1:0]};
  i2c_rate_select_line_monitor u_dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bus_unit_enable(bus_unit_enable), .clock_pull_low(clock_pull_low),
    .data_pull_low(data_pull_low), .port3_out_latch(port3_out_latch),
    .port3_pin_in(port3_pin_in), .port3_pin_out(port3_pin_out), .port3_pin_oe(port3_pin_oe),
    .clock_line_filtered(clock_line_filtered), .data_line_filtered(data_line_filtered),
    .bus_clock_enable(bus_clock_enable), .speed_mode_select(speed_mode_select),
    .noise_filter_enable(noise_filter_enable));
  bus_far_device u_far (.clock_oe(port3_pin_oe[CLOCK_PIN]), .clock_out(port3_pin_out[CLOCK_PIN]),
    .data_oe(port3_pin_oe[DATA_PIN]), .data_out(port3_pin_out[DATA_PIN]),
    .hold_clock_low(hold_clock_low), .hold_data_low(hold_data_low),
    .clock_line(clock_line), .data_line(data_line));

  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Write strobe for one cycle; model tracks what the register keeps
  task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    if (a == BUS_RATE_SELECT_ADDR) mdl_rate = d & 8'h0d;
    if (a == PORT3_DIRECTION_ADDR) mdl_dir = d | 8'h80;
  endtask
  // Read data sampled in the cycle after the strobe
  task automatic reg_read(input logic [15:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Spacing of bus clock pulses, bounded waits
  task automatic period(input int exp);
    int n;
    for (n = 0; n < 200 && bus_clock_enable !== 1'b1; n++) begin
      @(posedge mclk);
      #1;
    end
    n = 0;
    do begin
      @(posedge mclk);
      #1 n++;
    end while (bus_clock_enable !== 1'b1 && n < 200);
    check("divider period", exp[7:0], n[7:0]);
  endtask
  // Low pulse on the data line from the far device, filtered output watched
  task automatic pulse(input int len);
    first = -1;
    lows = 0;
    for (int i = 0; i < 20; i++) begin
      @(posedge mclk);
      hold_data_low <= (i < len);
      #1 if (data_line_filtered === 1'b0) begin
        lows++;
        if (first < 0) first = i;
      end
    end
  endtask

  // --------------------------------------------------------------
  // Watchdog
  // --------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    end_of_test();
  end

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 16'h0000; reg_wdata = 8'h00;
    bus_unit_enable = 1'b0; clock_pull_low = 1'b0; data_pull_low = 1'b0;
    port3_out_latch = 7'h00; other_in = 7'h00; hold_clock_low = 1'b0; hold_data_low = 1'b0;
    miscompares = 0; checks = 0; mdl_rate = 0; mdl_dir = 8'hff;
    void'($urandom(32'h1dc24aae));
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    // Reset values, one-cycle read data, unmapped place
    reg_read(BUS_RATE_SELECT_ADDR, rd); check("rate reset", 8'h00, rd);
    @(posedge mclk);
    #1 check("rdata after read", 8'h00, reg_rdata);
    reg_read(PORT3_DIRECTION_ADDR, rd); check("dir reset", 8'hff, rd);
    reg_write(16'hff00, 8'h0d);
    reg_read(16'hff00, rd); check("unmapped", 8'h00, rd);
    $display("test reset done");
    // Rate register fields with the unit stopped
    for (int i = 0; i < 8; i++) begin
      reg_write(BUS_RATE_SELECT_ADDR, (i == 0) ? 8'hff : 8'($urandom));
      #1 check("speed mode", {7'h0, mdl_rate[3]}, {7'h0, speed_mode_select});
      check("filter", {7'h0, mdl_rate[2]}, {7'h0, noise_filter_enable});
      reg_read(BUS_RATE_SELECT_ADDR, rd); check("rate read", mdl_rate[7:0], rd);
    end
    $display("test rate fields done");
    // Line level flags follow the lines while enabled
    reg_write(BUS_RATE_SELECT_ADDR, 8'h30);
    @(posedge mclk);
    bus_unit_enable <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      hold_clock_low <= 1'($urandom);
      hold_data_low <= 1'($urandom);
      other_in <= 7'($urandom);
      repeat (6) @(posedge mclk);
      #1 check("clock filtered", {7'h0, clock_line}, {7'h0, clock_line_filtered});
      reg_read(BUS_RATE_SELECT_ADDR, rd);
      check("line flags", {2'b00, clock_line, data_line, 4'h0}, rd);
    end
    @(posedge mclk);
    hold_clock_low <= 1'b0;
    hold_data_low <= 1'b0;
    bus_unit_enable <= 1'b0;
    repeat (6) @(posedge mclk);
    reg_read(BUS_RATE_SELECT_ADDR, rd); check("flags disabled", 8'h00, rd);
    $display("test line flags done");
    // Divider for every mode; unit stopped before each rate change
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk);
      bus_unit_enable <= 1'b0;
      reg_write(BUS_RATE_SELECT_ADDR, tab_rate[i][7:0]);
      bus_unit_enable <= 1'b1;
      period(tab_div[i]);
    end
    $display("test divider done");
    // Noise filter: short pulse kept when off, dropped and delayed when on
    pulse(1);
    check("unfiltered lows", 8'd1, lows[7:0]);
    check("unfiltered delay", 8'd3, first[7:0]);
    reg_write(BUS_RATE_SELECT_ADDR, 8'h0d);
    pulse(2);
    check("short pulse dropped", 8'd0, lows[7:0]);
    pulse(8);
    check("long pulse delayed", 8'd5, first[7:0]);
    check("long pulse seen", 8'd8, lows[7:0]);
    $display("test filter done");
    // Ordinary port pins with the unit stopped
    @(posedge mclk);
    bus_unit_enable <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      reg_write(PORT3_DIRECTION_ADDR, (i == 0) ? 8'h00 : 8'($urandom));
      port3_out_latch <= 7'($urandom);
      reg_read(PORT3_DIRECTION_ADDR, rd); check("dir read", mdl_dir[7:0], rd);
      repeat (2) @(posedge mclk);
      #1 check("pin oe", {1'b0, ~mdl_dir[6:0]}, {1'b0, port3_pin_oe});
      check("pin out", {1'b0, port3_out_latch}, {1'b0, port3_pin_out});
    end
    $display("test port pins done");
    // Bus pins as open-drain outputs driven by pull-low requests
    reg_write(PORT3_DIRECTION_ADDR, 8'hf3);
    port3_out_latch <= 7'h73;
    bus_unit_enable <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      clock_pull_low <= 1'($urandom);
      data_pull_low <= 1'($urandom);
      repeat (2) @(posedge mclk);
      #1 check("bus pin oe", {6'h0, clock_pull_low, data_pull_low},
        {6'h0, port3_pin_oe[CLOCK_PIN], port3_pin_oe[DATA_PIN]});
      check("bus pin out", 8'h00, {6'h0, port3_pin_out[CLOCK_PIN], port3_pin_out[DATA_PIN]});
      repeat (5) @(posedge mclk);
      reg_read(BUS_RATE_SELECT_ADDR, rd);
      check("driven flags", {2'b00, ~clock_pull_low, ~data_pull_low, mdl_rate[3:0]}, rd);
    end
    $display("test bus pins done");
    end_of_test();
  end
endmodule
`default_nettype wire
